// ---- hw/cbd_pkg.sv ----
package cbd_pkg;
  localparam int DW     = 8;
  localparam int CFG_W  = 16;
  localparam int CFG_N  = 8;
  localparam int CFG_AW = 3;
  localparam int FIFO_D = 4;
  localparam int NCOND  = 16;
  localparam int NROUTE = 6;
  localparam int NSTAT  = 8;

  // Routing input fields
  localparam int RI_ADDR = 0;
  localparam int RI_SI   = 3;
  localparam int RI_CIN  = 4;
  localparam int RI_HOLD = 5;

  // Bus register selects
  localparam logic [2:0] BR_A0   = 3'h0;
  localparam logic [2:0] BR_A1   = 3'h1;
  localparam logic [2:0] BR_D0   = 3'h2;
  localparam logic [2:0] BR_D1   = 3'h3;
  localparam logic [2:0] BR_F0   = 3'h4;
  localparam logic [2:0] BR_F1   = 3'h5;
  localparam logic [2:0] BR_CTRL = 3'h6;
  localparam logic [2:0] BR_STAT = 3'h7;

  // Condition indices
  localparam int C_EQ0 = 0;
  localparam int C_LT0 = 1;
  localparam int C_EQ1 = 2;
  localparam int C_LT1 = 3;
  localparam int C_Z0  = 4;
  localparam int C_Z1  = 5;
  localparam int C_FF0 = 6;
  localparam int C_FF1 = 7;
  localparam int C_OV  = 8;
  localparam int C_CO  = 9;
  localparam int C_SO  = 10;
  localparam int C_F0E = 11;
  localparam int C_F0F = 12;
  localparam int C_F1E = 13;
  localparam int C_F1F = 14;
  localparam int C_SOQ = 15;

  typedef enum logic [2:0] {
    OP_INC, OP_DEC, OP_ADD, OP_SUB, OP_AND, OP_OR, OP_XOR, OP_PASS
  } cbd_op_t;
  typedef enum logic [1:0] {SH_NONE, SH_LEFT, SH_RIGHT, SH_SWAP} cbd_shift_t;
  typedef enum logic [1:0] {SRC_A0, SRC_A1, SRC_D0, SRC_D1} cbd_src_t;
  typedef enum logic [1:0] {DST_NONE, DST_A0, DST_A1, DST_BOTH} cbd_dst_t;

  typedef struct packed {
    logic       f1_op;
    logic       f0_op;
    logic       crc_en;
    logic       carry_reg;
    cbd_dst_t   dst;
    logic       mask_en;
    cbd_shift_t shift;
    cbd_src_t   src_b;
    cbd_src_t   src_a;
    cbd_op_t    op;
  } cbd_cfg_t;

  typedef struct packed {
    logic cy;
    logic sd;
    logic eq;
    logic lt;
    logic z;
  } cbd_chain_t;

  typedef struct packed {
    logic f1_full;
    logic f1_empty;
    logic f0_full;
    logic f0_empty;
  } cbd_fstat_t;
endpackage : cbd_pkg

// ---- hw/cbd_datapath.sv ----
// What this block does
// - Eight-bit operands; chain neighbours for width
// - Two accumulators: ALU source, sink, compare source
// - Two data registers feed ALU and compares
// - Two four-byte FIFOs face the system bus
// - FIFOs load registers or capture accumulator/ALU
// - Eight 16-bit config words, routed address selects
// - ALU: inc, dec, add, sub, and, or, xor, pass
// - Shift, swap, OR mask independent of ALU op
// - Two masked comparators over accumulators and data
// - Zero, ones, overflow; selectable conditions routed out
// - Compare and detect chain to neighbour datapaths
// - Programmable MSB for arithmetic and shift
// - One CRC or sequence step per clock
// - Each FIFO independently input or output buffer
// - FIFO status selectable as datapath outputs
// - Carry, shift data, conditions chain to neighbours
// - Carry and shift-out registered for later reuse
// - Six routing inputs, six selectable routing outputs
// - Bus-writable control register drives routing
// - Read-only status register from datapath conditions 0 to 7
// - Sticky status bit cleared by firmware read
// - Datapath and status/control run separately
`timescale 1ns/1ps
`default_nettype none

module cbd_fifo #(
  parameter int W     = 8,
  parameter int DEPTH = 4
) (
  input  wire logic         clk,       // Clock
  input  wire logic         rst_n,     // Synchronised reset
  input  wire logic         in_valid,  // Write request
  output logic              in_ready,  // Room for a byte
  input  wire logic [W-1:0] in_data,   // Write data
  output logic              out_valid, // Byte available
  input  wire logic         out_ready, // Read request
  output logic [W-1:0]      out_data   // Head byte
);
  localparam int AW = $clog2(DEPTH);
  if (DEPTH < 2 || (1 << AW) != DEPTH) $error("DEPTH must be a power of two");

  logic [W-1:0] mem [DEPTH];
  logic [AW:0]  wptr;
  logic [AW:0]  rptr;
  wire          push = in_valid && in_ready;
  wire          pop  = out_valid && out_ready;

  assign in_ready  = (wptr - rptr) != (AW+1)'(DEPTH);
  assign out_valid = wptr != rptr;
  assign out_data  = mem[rptr[AW-1:0]];

  always_ff @(posedge clk) begin
    if (push) mem[wptr[AW-1:0]] <= in_data;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wptr <= '0;
      rptr <= '0;
    end else begin
      if (push) wptr <= wptr + 1'b1;
      if (pop) rptr <= rptr + 1'b1;
    end
  end

  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  fifo_full_a: assert property (
    in_valid && !in_ready && !pop |=> wptr == $past(wptr) && rptr == $past(rptr))
    else $error("full fifo accepted a write");
endmodule : cbd_fifo

module cbd_datapath #(
  parameter int FIFO_DEPTH = cbd_pkg::FIFO_D
) (
  input  wire logic                 clk,          // 250 MHz clock
  input  wire logic                 reset_n,      // Async reset, active low
  input  wire logic [5:0]           route_in,     // Routing inputs
  output logic [5:0]                route_out,    // Routing outputs
  input  wire logic [5:0][3:0]      route_sel,    // Condition per output
  input  wire cbd_pkg::cbd_chain_t  chain_in,     // From previous datapath
  output cbd_pkg::cbd_chain_t       chain_out,    // To next datapath
  input  wire logic                 chain_en,     // Use chain inputs
  input  wire logic                 cfg_we,       // Config word write
  input  wire logic [2:0]           cfg_waddr,    // Config word index
  input  wire logic [15:0]          cfg_wdata,    // Config word value
  input  wire logic [2:0]           msb_pos,      // Arithmetic MSB
  input  wire logic [7:0]           or_mask,      // Output OR mask
  input  wire logic [7:0]           cmp_mask0,    // Compare 0 mask
  input  wire logic [7:0]           cmp_mask1,    // Compare 1 mask
  input  wire logic                 cmp1_use_a1,  // Compare 1 A1 else A0
  input  wire logic [1:0]           fifo_out_mode,// 1: output buffer
  input  wire logic                 fifo_to_d,    // FIFO loads D not A
  input  wire logic                 dp_run,       // Datapath running
  input  wire logic                 sc_run,       // Status/control running
  input  wire logic [7:0]           stat_sticky,  // Latched status bits
  input  wire logic                 bus_wr,       // Bus write strobe
  input  wire logic                 bus_rd,       // Bus read strobe
  input  wire logic [2:0]           bus_addr,     // Register select
  input  wire logic [7:0]           bus_wdata,    // Write data
  output logic [7:0]                bus_rdata,    // Read data
  output logic                      bus_rvalid,   // Read data valid
  output logic [7:0]                ctrl_out,     // Control to routing
  output cbd_pkg::cbd_fstat_t       fifo_stat     // FIFO flags
);
  if (cbd_pkg::DW != 8) $error("operand width must be eight");

  logic rs1;
  logic rst_n;
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rs1   <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rs1   <= 1'b1;
      rst_n <= rs1;
    end
  end

  logic [7:0] acc0, acc1, dr0, dr1;
  logic       carry_q, so_q;
  logic [7:0] stat_latch;
  logic [cbd_pkg::CFG_W-1:0] cfg_ram [cbd_pkg::CFG_N];

  function automatic logic [7:0] pick(input cbd_pkg::cbd_src_t s,
      input logic [7:0] a0, a1, d0, d1);
    case (s)
      cbd_pkg::SRC_A0: pick = a0;
      cbd_pkg::SRC_A1: pick = a1;
      cbd_pkg::SRC_D0: pick = d0;
      default:         pick = d1;
    endcase
  endfunction : pick

  // Config RAM, per-cycle word chosen by routing
  always_ff @(posedge clk) begin
    if (cfg_we) cfg_ram[cfg_waddr] <= cfg_wdata;
  end
  wire [2:0] cfg_addr = route_in[cbd_pkg::RI_ADDR +: cbd_pkg::CFG_AW];
  cbd_pkg::cbd_cfg_t cfg;
  assign cfg = cbd_pkg::cbd_cfg_t'(cfg_ram[cfg_addr]);

  // FIFOs
  logic [1:0] fin_v, fin_r, fout_v, fout_r;
  logic [1:0][7:0] fin_d, fout_d;
  wire [1:0] bus_fsel = {bus_addr == cbd_pkg::BR_F1, bus_addr == cbd_pkg::BR_F0};
  wire [1:0] dp_fop   = {cfg.f1_op, cfg.f0_op};
  logic [7:0] res;
  // Datapath FIFO op that cannot proceed stalls the whole cycle
  wire [1:0] f_block = dp_fop & ~((fifo_out_mode & fin_r) | (~fifo_out_mode & fout_v));
  wire run = dp_run && !route_in[cbd_pkg::RI_HOLD] && !(|f_block);
  wire [1:0] dp_fire = dp_fop & {2{run}};

  for (genvar i = 0; i < 2; i++) begin : g_fifo
    // Input buffer: bus fills, datapath drains; output reversed
    assign fin_v[i] = fifo_out_mode[i] ? dp_fire[i] : bus_wr && bus_fsel[i];
    assign fin_d[i] = fifo_out_mode[i] ? (i == 0 ? res : acc1) : bus_wdata;
    assign fout_r[i] = fifo_out_mode[i] ? bus_rd && bus_fsel[i] : dp_fire[i];
    cbd_fifo #(.W(cbd_pkg::DW), .DEPTH(FIFO_DEPTH)) u_fifo (
      .clk       (clk),
      .rst_n     (rst_n),
      .in_valid  (fin_v[i]),
      .in_ready  (fin_r[i]),
      .in_data   (fin_d[i]),
      .out_valid (fout_v[i]),
      .out_ready (fout_r[i]),
      .out_data  (fout_d[i])
    );
  end

  // ALU operands and carry/shift-in selection
  wire [7:0] wmask = 8'hff >> (3'h7 - msb_pos);
  wire [7:0] opa = pick(cfg.src_a, acc0, acc1, dr0, dr1) & wmask;
  wire [7:0] opb = pick(cfg.src_b, acc0, acc1, dr0, dr1) & wmask;
  wire cin = cfg.carry_reg ? carry_q : (chain_en ? chain_in.cy : route_in[cbd_pkg::RI_CIN]);
  wire sin = cfg.carry_reg ? so_q : (chain_en ? chain_in.sd : route_in[cbd_pkg::RI_SI]);

  logic [8:0] sum;
  always_comb begin
    case (cfg.op)
      cbd_pkg::OP_INC:  sum = {1'b0, opa} + 9'h001;
      cbd_pkg::OP_DEC:  sum = {1'b0, opa} - 9'h001;
      cbd_pkg::OP_ADD:  sum = {1'b0, opa} + {1'b0, opb} + {8'h00, cin};
      cbd_pkg::OP_SUB:  sum = {1'b0, opa} - {1'b0, opb};
      cbd_pkg::OP_AND:  sum = {1'b0, opa & opb};
      cbd_pkg::OP_OR:   sum = {1'b0, opa | opb};
      cbd_pkg::OP_XOR:  sum = {1'b0, opa ^ opb};
      default:          sum = {1'b0, opa};
    endcase
  end
  wire [7:0] alu  = sum[7:0] & wmask;
  wire [3:0] cpos = {1'b0, msb_pos} + 4'h1;
  wire cout = sum[cpos];
  wire ov = (opa[msb_pos] == opb[msb_pos]) && (alu[msb_pos] != opa[msb_pos]);

  // CRC step: shift A left, fold polynomial from B on feedback
  wire fb = opa[msb_pos] ^ sin;
  wire [7:0] crc = ((opa << 1) & wmask) ^ (fb ? opb : 8'h00);

  logic [7:0] shv;
  logic       sout;
  always_comb begin
    case (cfg.shift)
      cbd_pkg::SH_LEFT:  shv = ((alu << 1) | {7'h00, sin}) & wmask;
      cbd_pkg::SH_RIGHT: shv = (alu >> 1) | ({7'h00, sin} << msb_pos);
      cbd_pkg::SH_SWAP:  shv = {alu[3:0], alu[7:4]};
      default:           shv = alu;
    endcase
    case (cfg.shift)
      cbd_pkg::SH_LEFT:  sout = alu[msb_pos];
      cbd_pkg::SH_RIGHT: sout = alu[0];
      default:           sout = opa[msb_pos];
    endcase
  end
  wire [7:0] shm = cfg.mask_en ? (shv | or_mask) : shv;
  assign res = cfg.crc_en ? crc : shm;

  // Compares and detects; compare 0 and zero 0 chained from the less significant side
  wire [7:0] c1a = cmp1_use_a1 ? acc1 : acc0;
  wire eq0l = ((acc0 ^ dr0) & cmp_mask0) == 8'h00;
  wire lt0l = (acc0 & cmp_mask0) < (dr0 & cmp_mask0);
  wire eq1l = ((c1a ^ dr1) & cmp_mask1) == 8'h00;
  wire lt1l = (c1a & cmp_mask1) < (dr1 & cmp_mask1);
  wire eq0 = eq0l && (!chain_en || chain_in.eq);
  wire lt0 = lt0l || (eq0l && chain_en && chain_in.lt);
  wire z0 = (acc0 == 8'h00) && (!chain_en || chain_in.z);
  wire z1 = acc1 == 8'h00;

  logic [cbd_pkg::NCOND-1:0] cond;
  always_comb begin
    cond = '0;
    cond[cbd_pkg::C_EQ0] = eq0;
    cond[cbd_pkg::C_LT0] = lt0;
    cond[cbd_pkg::C_EQ1] = eq1l;
    cond[cbd_pkg::C_LT1] = lt1l;
    cond[cbd_pkg::C_Z0]  = z0;
    cond[cbd_pkg::C_Z1]  = z1;
    cond[cbd_pkg::C_FF0] = (acc0 & wmask) == wmask;
    cond[cbd_pkg::C_FF1] = (acc1 & wmask) == wmask;
    cond[cbd_pkg::C_OV]  = ov;
    cond[cbd_pkg::C_CO]  = cout;
    cond[cbd_pkg::C_SO]  = sout;
    cond[cbd_pkg::C_F0E] = !fout_v[0];
    cond[cbd_pkg::C_F0F] = !fin_r[0];
    cond[cbd_pkg::C_F1E] = !fout_v[1];
    cond[cbd_pkg::C_F1F] = !fin_r[1];
    cond[cbd_pkg::C_SOQ] = so_q;
  end

  // Bus decode; a bus write beats a datapath write to the same register
  wire [7:0] bw = {8{bus_wr}} & (8'h01 << bus_addr);
  wire ld_a0 = run && (cfg.dst == cbd_pkg::DST_A0 || cfg.dst == cbd_pkg::DST_BOTH);
  wire ld_a1 = run && (cfg.dst == cbd_pkg::DST_A1 || cfg.dst == cbd_pkg::DST_BOTH);
  wire [1:0] f_to_reg = dp_fire & ~fifo_out_mode;
  wire stat_rd = bus_rd && bus_addr == cbd_pkg::BR_STAT && sc_run;
  wire [7:0] stat_src = cond[cbd_pkg::NSTAT-1:0];
  wire [7:0] stat_val = (stat_latch & stat_sticky) | (stat_src & ~stat_sticky);

  logic [7:0] next_rdata;
  always_comb begin
    case (bus_addr)
      cbd_pkg::BR_A0:   next_rdata = acc0;
      cbd_pkg::BR_A1:   next_rdata = acc1;
      cbd_pkg::BR_D0:   next_rdata = dr0;
      cbd_pkg::BR_D1:   next_rdata = dr1;
      cbd_pkg::BR_F0:   next_rdata = fout_r[0] && fout_v[0] ? fout_d[0] : 8'h00;
      cbd_pkg::BR_F1:   next_rdata = fout_r[1] && fout_v[1] ? fout_d[1] : 8'h00;
      cbd_pkg::BR_CTRL: next_rdata = ctrl_out;
      default:          next_rdata = stat_val;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      acc0 <= 8'h00;
      acc1 <= 8'h00;
      dr0  <= 8'h00;
      dr1  <= 8'h00;
    end else begin
      if (bw[cbd_pkg::BR_A0]) acc0 <= bus_wdata;
      else if (f_to_reg[0] && !fifo_to_d) acc0 <= fout_d[0];
      else if (ld_a0) acc0 <= res;
      if (bw[cbd_pkg::BR_A1]) acc1 <= bus_wdata;
      else if (f_to_reg[1] && !fifo_to_d) acc1 <= fout_d[1];
      else if (ld_a1) acc1 <= res;
      if (bw[cbd_pkg::BR_D0]) dr0 <= bus_wdata;
      else if (f_to_reg[0] && fifo_to_d) dr0 <= fout_d[0];
      if (bw[cbd_pkg::BR_D1]) dr1 <= bus_wdata;
      else if (f_to_reg[1] && fifo_to_d) dr1 <= fout_d[1];
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      carry_q <= 1'b0;
      so_q    <= 1'b0;
    end else if (run) begin
      carry_q <= cout;
      so_q    <= sout;
    end
  end

  // Outputs are all registered
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      route_out  <= '0;
      chain_out  <= '0;
      fifo_stat  <= '0;
      bus_rdata  <= 8'h00;
      bus_rvalid <= 1'b0;
    end else begin
      for (int i = 0; i < cbd_pkg::NROUTE; i++) route_out[i] <= cond[route_sel[i]];
      chain_out  <= '{cy: cout, sd: sout, eq: eq0, lt: lt0, z: z0};
      fifo_stat  <= '{f1_full: !fin_r[1], f1_empty: !fout_v[1],
                      f0_full: !fin_r[0], f0_empty: !fout_v[0]};
      bus_rdata  <= bus_rd ? next_rdata : bus_rdata;
      bus_rvalid <= bus_rd;
    end
  end

  // Status/control; set beats a same-cycle read clear
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_out   <= 8'h00;
      stat_latch <= 8'h00;
    end else if (sc_run) begin
      if (bw[cbd_pkg::BR_CTRL]) ctrl_out <= bus_wdata;
      stat_latch <= ((stat_rd ? 8'h00 : stat_latch) | stat_src) & stat_sticky;
    end
  end

  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);

  cfg_select_a: assert property (
    run && cfg.dst == cbd_pkg::DST_A0 && !bw[cbd_pkg::BR_A0] && !f_to_reg[0]
    |=> acc0 == $past(res))
    else $error("applied config word not the routed one");
  acc_bus_a: assert property (bw[cbd_pkg::BR_A0] |=> acc0 == $past(bus_wdata))
    else $error("accumulator bus write lost");
  data_reg_a: assert property (
    $changed(dr0) |-> $past(bw[cbd_pkg::BR_D0] || (f_to_reg[0] && fifo_to_d)))
    else $error("data register took an ALU result");
  carry_hold_a: assert property (run |=> carry_q == $past(cout))
    else $error("carry not registered");
  route_zero_a: assert property (
    route_sel[0] == 4'h4 |=> route_out[0] == $past(z0))
    else $error("routing output wrong condition");
  ctrl_write_a: assert property (
    sc_run && bw[cbd_pkg::BR_CTRL] |=> ctrl_out == $past(bus_wdata))
    else $error("control write lost");
  stat_clear_a: assert property (
    stat_rd |=> (stat_latch & ~$past(stat_src)) == 8'h00)
    else $error("sticky status not cleared by read");
  eq_chain_a: assert property (chain_en && !chain_in.eq |-> !cond[cbd_pkg::C_EQ0])
    else $error("chained compare ignores neighbour");
endmodule : cbd_datapath

`default_nettype wire

// ---- bench/cbd_bus_master.sv ----
`timescale 1ns/1ps
`default_nettype none

module cbd_bus_master (
  input  wire logic       clk,        // Datapath clock
  output logic            bus_wr,     // Write strobe
  output logic            bus_rd,     // Read strobe
  output logic [2:0]      bus_addr,   // Register select
  output logic [7:0]      bus_wdata,  // Write data
  input  wire logic [7:0] bus_rdata,  // Read data
  input  wire logic       bus_rvalid  // Read data valid
);
  initial begin
    bus_wr    = 1'b0;
    bus_rd    = 1'b0;
    bus_addr  = 3'h0;
    bus_wdata = 8'h00;
  end

  // Firmware loads operands one byte per strobe
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk);
    bus_wr    <= 1'b1;
    bus_addr  <= a;
    bus_wdata <= d;
    @(posedge clk);
    bus_wr    <= 1'b0;
    // Released data shows the inverse so a stale byte is never mistaken
    bus_wdata <= ~d;
  endtask : wr

  // Firmware collects results; answer sampled 1 ns after the taken edge
  task automatic rd(input logic [2:0] a, output logic [7:0] d, output logic v);
    @(posedge clk);
    bus_rd   <= 1'b1;
    bus_addr <= a;
    @(posedge clk);
    bus_rd   <= 1'b0;
    #1;
    v = bus_rvalid;
    d = bus_rdata;
  endtask : rd
endmodule : cbd_bus_master

`default_nettype wire

// ---- bench/tb.sv ----
`timescale 1ns/1ps
`default_nettype none

module tb;
  typedef struct packed {
    cbd_pkg::cbd_op_t    op;
    cbd_pkg::cbd_shift_t sh;
    logic                mk;
    logic [7:0]          a;
    logic [7:0]          b;
    logic [7:0]          r;
  } cbd_row_t;

  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic [5:0] route_in = 6'h00;
  logic [5:0] route_out;
  logic [5:0][3:0] route_sel = {4'ha, 4'h9, 4'hb, 4'hc, 4'h6, 4'h4};
  cbd_pkg::cbd_chain_t chain_in = '0;
  cbd_pkg::cbd_chain_t chain_out;
  logic chain_en = 1'b0;
  logic cfg_we = 1'b0;
  logic [2:0] cfg_waddr = 3'h0;
  logic [15:0] cfg_wdata = 16'h0000;
  logic [2:0] msb_pos = 3'h7;
  logic [7:0] or_mask = 8'h0f;
  logic [7:0] cmp_mask0 = 8'hff;
  logic [7:0] cmp_mask1 = 8'hff;
  logic cmp1_use_a1 = 1'b0;
  logic [1:0] fifo_out_mode = 2'h0;
  logic fifo_to_d = 1'b0;
  logic dp_run = 1'b0;
  logic sc_run = 1'b1;
  logic [7:0] stat_sticky = 8'h00;
  logic bus_wr, bus_rd, bus_rvalid;
  logic [2:0] bus_addr;
  logic [7:0] bus_wdata, bus_rdata, ctrl_out, rv;
  logic vv;
  cbd_pkg::cbd_fstat_t fifo_stat;
  int error_cnt = 0;
  int samples_checked = 0;
  int cyc = 0;

  cbd_row_t rows [12] = '{
    '{cbd_pkg::OP_INC,  cbd_pkg::SH_NONE,  1'b0, 8'hff, 8'h00, 8'h00},
    '{cbd_pkg::OP_DEC,  cbd_pkg::SH_NONE,  1'b0, 8'h00, 8'h00, 8'hff},
    '{cbd_pkg::OP_ADD,  cbd_pkg::SH_NONE,  1'b0, 8'h7f, 8'h01, 8'h80},
    '{cbd_pkg::OP_SUB,  cbd_pkg::SH_NONE,  1'b0, 8'h10, 8'h20, 8'hf0},
    '{cbd_pkg::OP_AND,  cbd_pkg::SH_NONE,  1'b0, 8'hf0, 8'h3c, 8'h30},
    '{cbd_pkg::OP_OR,   cbd_pkg::SH_NONE,  1'b0, 8'hf0, 8'h0c, 8'hfc},
    '{cbd_pkg::OP_XOR,  cbd_pkg::SH_NONE,  1'b0, 8'hff, 8'h0f, 8'hf0},
    '{cbd_pkg::OP_PASS, cbd_pkg::SH_NONE,  1'b0, 8'h5a, 8'h00, 8'h5a},
    '{cbd_pkg::OP_PASS, cbd_pkg::SH_LEFT,  1'b0, 8'h5a, 8'h00, 8'hb4},
    '{cbd_pkg::OP_PASS, cbd_pkg::SH_RIGHT, 1'b0, 8'h5a, 8'h00, 8'h2d},
    '{cbd_pkg::OP_PASS, cbd_pkg::SH_SWAP,  1'b0, 8'h5a, 8'h00, 8'ha5},
    '{cbd_pkg::OP_PASS, cbd_pkg::SH_NONE,  1'b1, 8'h50, 8'h00, 8'h5f}
  };

  cbd_bus_master i_cbd_bus_master (.clk(clk), .bus_wr(bus_wr), .bus_rd(bus_rd),
    .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_rdata(bus_rdata),
    .bus_rvalid(bus_rvalid));

  cbd_datapath i_cbd_datapath (.clk(clk), .reset_n(reset_n), .route_in(route_in),
    .route_out(route_out), .route_sel(route_sel), .chain_in(chain_in),
    .chain_out(chain_out), .chain_en(chain_en), .cfg_we(cfg_we), .cfg_waddr(cfg_waddr),
    .cfg_wdata(cfg_wdata), .msb_pos(msb_pos), .or_mask(or_mask), .cmp_mask0(cmp_mask0),
    .cmp_mask1(cmp_mask1), .cmp1_use_a1(cmp1_use_a1), .fifo_out_mode(fifo_out_mode),
    .fifo_to_d(fifo_to_d), .dp_run(dp_run), .sc_run(sc_run), .stat_sticky(stat_sticky),
    .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
    .bus_rdata(bus_rdata), .bus_rvalid(bus_rvalid), .ctrl_out(ctrl_out),
    .fifo_stat(fifo_stat));

  initial begin
    forever #2 clk = ~clk;
  end

  task automatic test_done;
    $display("checks %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : test_done

  // Bound on the whole run; a hang ends in the same report
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      error_cnt++;
      test_done();
    end
  end

  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic rdchk(input logic [2:0] a, input logic [7:0] exp);
    i_cbd_bus_master.rd(a, rv, vv);
    check("read data", rv, exp);
    check("read valid", {7'h00, vv}, 8'h01);
  endtask : rdchk

  task automatic cfg(input logic [2:0] idx, input cbd_pkg::cbd_cfg_t c);
    @(posedge clk);
    cfg_we    <= 1'b1;
    cfg_waddr <= idx;
    cfg_wdata <= c;
    @(posedge clk);
    cfg_we    <= 1'b0;
  endtask : cfg

  task automatic step(input logic [2:0] idx);
    @(posedge clk);
    route_in <= {3'h0, idx};
    dp_run   <= 1'b1;
    @(posedge clk);
    dp_run   <= 1'b0;
  endtask : step

  task automatic run(input cbd_row_t r, input logic cr, input logic [1:0] fop);
    cbd_pkg::cbd_cfg_t c;
    c = '0;
    c.op = r.op;
    c.shift = r.sh;
    c.mask_en = r.mk;
    c.src_a = cbd_pkg::SRC_A0;
    c.src_b = cbd_pkg::SRC_D0;
    c.dst = (fop == 2'h0) ? cbd_pkg::DST_A0 : cbd_pkg::DST_NONE;
    c.carry_reg = cr;
    c.f0_op = (fop != 2'h0);
    cfg(3'h1 + {1'b0, fop}, c);
    i_cbd_bus_master.wr(3'h0, r.a);
    i_cbd_bus_master.wr(3'h2, r.b);
    if (fop == 2'h0) step(3'h1);
  endtask : run

  initial begin
    repeat (10) @(posedge clk);
    check("ctrl in reset", ctrl_out, 8'h00);
    check("fifo flags in reset", {4'h0, fifo_stat}, 8'h00);
    check("valid in reset", {7'h00, bus_rvalid}, 8'h00);
    repeat (10) @(posedge clk);
    reset_n <= 1'b1;
    repeat (5) @(posedge clk);
    check("fifo flags idle", {4'h0, fifo_stat}, 8'h05);
    for (int i = 0; i < 12; i++) begin
      run(rows[i], 1'b0, 2'h0);
      rdchk(3'h0, rows[i].r);
      check("zero out", {7'h00, route_out[0]}, {7'h00, rows[i].r == 8'h00});
      check("ones out", {7'h00, route_out[1]}, {7'h00, rows[i].r == 8'hff});
    end
    // Carry kept from one step feeds the next
    run('{cbd_pkg::OP_ADD, cbd_pkg::SH_NONE, 1'b0, 8'hff, 8'h01, 8'h00}, 1'b0, 2'h0);
    run('{cbd_pkg::OP_ADD, cbd_pkg::SH_NONE, 1'b0, 8'h00, 8'h01, 8'h02}, 1'b1, 2'h0);
    rdchk(3'h0, 8'h02);
    // Input queue: fill past full, drain, then stall on empty
    run('{cbd_pkg::OP_PASS, cbd_pkg::SH_NONE, 1'b0, 8'h00, 8'h00, 8'h00}, 1'b0, 2'h1);
    for (int k = 1; k <= 5; k++) i_cbd_bus_master.wr(3'h4, 8'(8'h11 * k));
    repeat (2) @(posedge clk);
    check("fifo full flags", {4'h0, fifo_stat}, 8'h06);
    check("full out", {7'h00, route_out[2]}, 8'h01);
    for (int k = 1; k <= 4; k++) begin
      step(3'h2);
      rdchk(3'h0, 8'(8'h11 * k));
    end
    step(3'h2);
    rdchk(3'h0, 8'h44);
    check("empty out", {7'h00, route_out[3]}, 8'h01);
    check("fifo empty flags", {4'h0, fifo_stat}, 8'h05);
    // Output queue captures the result for the bus
    @(posedge clk) fifo_out_mode <= 2'h1;
    run('{cbd_pkg::OP_PASS, cbd_pkg::SH_NONE, 1'b0, 8'h3c, 8'h00, 8'h00}, 1'b0, 2'h2);
    step(3'h3);
    rdchk(3'h4, 8'h3c);
    rdchk(3'h4, 8'h00);
    // Control writes ignored while its clock is stopped
    @(posedge clk) sc_run <= 1'b0;
    i_cbd_bus_master.wr(3'h6, 8'h96);
    repeat (2) @(posedge clk);
    check("ctrl stopped", ctrl_out, 8'h00);
    @(posedge clk) sc_run <= 1'b1;
    i_cbd_bus_master.wr(3'h6, 8'h96);
    repeat (2) @(posedge clk);
    check("ctrl out", ctrl_out, 8'h96);
    // Transient zero latched until read
    @(posedge clk) stat_sticky <= 8'h10;
    i_cbd_bus_master.wr(3'h0, 8'h00);
    i_cbd_bus_master.wr(3'h0, 8'h05);
    repeat (2) @(posedge clk);
    i_cbd_bus_master.rd(3'h7, rv, vv);
    check("sticky set", rv & 8'h10, 8'h10);
    i_cbd_bus_master.rd(3'h7, rv, vv);
    check("sticky clear", rv & 8'h10, 8'h00);
    // Neighbour carry and compare flags chained in
    @(posedge clk) chain_en <= 1'b1;
    chain_in <= '{cy: 1'b1, sd: 1'b0, eq: 1'b0, lt: 1'b1, z: 1'b1};
    run('{cbd_pkg::OP_ADD, cbd_pkg::SH_NONE, 1'b0, 8'h05, 8'h05, 8'h0b}, 1'b0, 2'h0);
    rdchk(3'h0, 8'h0b);
    i_cbd_bus_master.wr(3'h0, 8'h05);
    repeat (2) @(posedge clk);
    check("chain kills equal", {3'h0, chain_out}, 8'h02);
    @(posedge clk) chain_in.eq <= 1'b1;
    repeat (2) @(posedge clk);
    check("chain passes equal", {3'h0, chain_out}, 8'h06);
    // Second reset in mid-run clears the control outputs
    @(posedge clk) reset_n <= 1'b0;
    repeat (3) @(posedge clk);
    check("ctrl after reset", ctrl_out, 8'h00);
    reset_n <= 1'b1;
    repeat (5) @(posedge clk);
    test_done();
  end
endmodule : tb

`default_nettype wire
